// file: design/aldc_config.sv
// The address map and the plain strobed port were decided locally.
`timescale 1ns/1ps

module aldc_config (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [5:0] adr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic [12:0] msg_adr_i,
  input wire logic [5:0] enc_req_i,
  input wire logic [5:0] hdr_mismatch_i,
  input wire logic [5:0] obsai_mode_i,
  output aldc_pkg::aldc_dest_s decomb0_dest_o,
  output aldc_pkg::aldc_link_s [5:0] link_cfg_o,
  output logic [5:0] agg_to_mac_en_o,
  output logic [5:0] agg_use_comb_o,
  output logic [5:0] agg_use_enc_o,
  output logic [5:0] agg_honour_enc_o,
  output logic [5:0] agg_pick_enc_o,
  output logic [9:0] lut_index_o
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [31:0] dest;
    logic [31:0] dec_link;
    logic [31:0] dec_capofs;
    logic [31:0] dec_adrmux;
    logic [5:0][3:0] agg;
    logic [5:0][1:0] agg_live;
    logic [5:0] agg_on;
    logic [5:0][1:0] cin;
    logic [5:0][1:0] cout;
    logic [31:0] rdata;
    logic [9:0] index;
  } aldc_state_s;

  aldc_state_s s_q;
  aldc_state_s s_d;
  aldc_pkg::aldc_bus_s bus;

  assign bus = '{adr: adr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [2:0] link_slot(input logic [5:0] adr, input logic [5:0] base);
    logic [5:0] diff;
    diff = adr - base;
    if (adr >= base && diff < 6'h06) begin
      return diff[2:0];
    end
    return 3'h7;
  endfunction : link_slot

  function automatic logic [2:0] ofs_eff(input logic [2:0] ofs, input logic burst8);
    return burst8 ? {ofs[2:1], 1'b0} : ofs;
  endfunction : ofs_eff

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    logic [2:0] slot;
    logic [3:0] bitpos;
    slot = 3'h7;
    bitpos = 4'h0;
    s_d = s_q;
    s_d.rdata = aldc_pkg::RESET_VALUE;
    if (bus.wr) begin
      case (bus.adr)
        aldc_pkg::ADR_DECOMB_DEST: s_d.dest = bus.wdata & aldc_pkg::MASK_DECOMB_DEST;
        aldc_pkg::ADR_DEC_LINK: s_d.dec_link = bus.wdata & aldc_pkg::MASK_DEC_LINK;
        aldc_pkg::ADR_DEC_CAPOFS: s_d.dec_capofs = bus.wdata & aldc_pkg::MASK_DEC_CAPOFS;
        aldc_pkg::ADR_DEC_ADRMUX: s_d.dec_adrmux = bus.wdata & aldc_pkg::MASK_DEC_ADRMUX;
        default: begin
          slot = link_slot(bus.adr, aldc_pkg::ADR_AGG_BASE);
          if (slot != 3'h7) begin
            s_d.agg[slot] = bus.wdata[3:0];
          end
          slot = link_slot(bus.adr, aldc_pkg::ADR_CIN_BASE);
          if (slot != 3'h7) begin
            s_d.cin[slot] = bus.wdata[1:0];
          end
          slot = link_slot(bus.adr, aldc_pkg::ADR_COUT_BASE);
          if (slot != 3'h7) begin
            s_d.cout[slot] = bus.wdata[1:0];
          end
        end
      endcase
    end
    // mode is latched only on a disabled-to-enabled edge of the link
    for (int i = 0; i < 6; i++) begin
      if (s_d.agg[i][1:0] == aldc_pkg::AGG_OFF) begin
        s_d.agg_on[i] = 1'b0;
        s_d.agg_live[i] = aldc_pkg::AGG_OFF;
      end else if (!s_q.agg_on[i]) begin
        s_d.agg_on[i] = 1'b1;
        s_d.agg_live[i] = s_d.agg[i][1:0];
      end
    end
    if (bus.rd) begin
      case (bus.adr)
        aldc_pkg::ADR_DECOMB_DEST: s_d.rdata = s_q.dest;
        aldc_pkg::ADR_DEC_LINK: s_d.rdata = s_q.dec_link;
        aldc_pkg::ADR_DEC_CAPOFS: s_d.rdata = s_q.dec_capofs;
        aldc_pkg::ADR_DEC_ADRMUX: s_d.rdata = s_q.dec_adrmux;
        aldc_pkg::ADR_STATUS: begin
          for (int i = 0; i < 6; i++) begin
            s_d.rdata[2*i +: 2] = s_q.agg_live[i];
          end
          s_d.rdata[16 +: 6] = s_q.agg_on;
        end
        default: begin
          slot = link_slot(bus.adr, aldc_pkg::ADR_AGG_BASE);
          if (slot != 3'h7) begin
            s_d.rdata = {28'h0, s_q.agg[slot]};
          end
          slot = link_slot(bus.adr, aldc_pkg::ADR_CIN_BASE);
          if (slot != 3'h7) begin
            s_d.rdata = {30'h0, s_q.cin[slot]};
          end
          slot = link_slot(bus.adr, aldc_pkg::ADR_COUT_BASE);
          if (slot != 3'h7) begin
            s_d.rdata = {30'h0, s_q.cout[slot]};
          end
        end
      endcase
    end
    // lookup index: index bit n takes message address bit n plus control
    for (int n = 0; n < 10; n++) begin
      bitpos = 4'(n) + {2'h0, s_q.dec_adrmux[2*n +: 2]};
      s_d.index[n] = msg_adr_i[bitpos];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign rdata_o = s_q.rdata;
  assign lut_index_o = s_q.index;

  always_comb begin
    for (int e = 0; e < 4; e++) begin
      decomb0_dest_o.link[e] = s_q.dest[4*e +: 3];
      decomb0_dest_o.valid[e] = s_q.dest[4*e +: 3] < aldc_pkg::DEST_EMPTY_MIN;
    end
  end

  always_comb begin
    for (int i = 0; i < 6; i++) begin
      link_cfg_o[i].dest = 4'h0;
      link_cfg_o[i].agg_mode = s_q.agg_live[i];
      link_cfg_o[i].agg_err_en = s_q.agg[i][2];
      link_cfg_o[i].hdr_sel = s_q.agg[i][3];
      link_cfg_o[i].cin_fmt = s_q.cin[i];
      link_cfg_o[i].cout_fmt = s_q.cout[i];
      link_cfg_o[i].dec_en = s_q.dec_link[aldc_pkg::DEC_EN_LSB + i];
      link_cfg_o[i].dec_burst8 = s_q.dec_link[aldc_pkg::DEC_BURST_LSB + i];
      link_cfg_o[i].cpri_fmt = s_q.dec_link[aldc_pkg::DEC_FMT_LSB + 2*i +: 2];
      link_cfg_o[i].cap_en = s_q.dec_capofs[aldc_pkg::CAP_EN_LSB + i];
      link_cfg_o[i].ram_ofs = ofs_eff(s_q.dec_capofs[3*i +: 3],
                                      s_q.dec_link[aldc_pkg::DEC_BURST_LSB + i]);
      for (int e = 0; e < 4; e++) begin
        if (decomb0_dest_o.valid[e] && decomb0_dest_o.link[e] == 3'(i)) begin
          link_cfg_o[i].dest[e] = 1'b1;
        end
      end
      agg_to_mac_en_o[i] = s_q.agg_live[i] != aldc_pkg::AGG_OFF;
      agg_use_comb_o[i] = s_q.agg_live[i][0];
      agg_use_enc_o[i] = s_q.agg_live[i][1];
      agg_honour_enc_o[i] = s_q.agg_live[i][1] && enc_req_i[i];
      agg_pick_enc_o[i] = agg_use_comb_o[i] && !agg_use_enc_o[i] ? 1'b0 :
                          (agg_use_enc_o[i] && !agg_use_comb_o[i]) ? enc_req_i[i] :
                          (enc_req_i[i] && (!hdr_mismatch_i[i] || !obsai_mode_i[i] ||
                           s_q.agg[i][3]));
    end
  end

endmodule : aldc_config

// file: design/aldc_pkg.sv
package aldc_pkg;

  // ------------------------------------------------------------
  // register map (word index; byte address is index times four)
  // ------------------------------------------------------------
  localparam int unsigned NUM_LINKS = 6;
  localparam logic [5:0] ADR_DECOMB_DEST = 6'h00;
  localparam logic [5:0] ADR_DEC_LINK = 6'h01;
  localparam logic [5:0] ADR_DEC_CAPOFS = 6'h02;
  localparam logic [5:0] ADR_DEC_ADRMUX = 6'h03;
  localparam logic [5:0] ADR_AGG_BASE = 6'h08;
  localparam logic [5:0] ADR_CIN_BASE = 6'h10;
  localparam logic [5:0] ADR_COUT_BASE = 6'h18;
  localparam logic [5:0] ADR_STATUS = 6'h20;

  // ------------------------------------------------------------
  // writable masks and reset values
  // ------------------------------------------------------------
  localparam logic [31:0] MASK_DECOMB_DEST = 32'h0000_7777;
  localparam logic [31:0] MASK_AGG = 32'h0000_000F;
  localparam logic [31:0] MASK_FMT = 32'h0000_0003;
  localparam logic [31:0] MASK_DEC_LINK = 32'h0FFF_3F3F;
  localparam logic [31:0] MASK_DEC_CAPOFS = 32'h3F03_FFFF;
  localparam logic [31:0] MASK_DEC_ADRMUX = 32'h000F_FFFF;
  localparam logic [31:0] RESET_VALUE = 32'h0000_0000;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int unsigned DEC_EN_LSB = 0;
  localparam int unsigned DEC_BURST_LSB = 8;
  localparam int unsigned DEC_FMT_LSB = 16;
  localparam int unsigned CAP_EN_LSB = 24;
  localparam logic [2:0] DEST_EMPTY_MIN = 3'h6;

  typedef enum logic [1:0] {
    AGG_OFF = 2'h0,
    AGG_PASS = 2'h1,
    AGG_INSERT = 2'h2,
    AGG_ALL = 2'h3
  } aldc_mode_e;

  typedef enum logic [1:0] {
    FMT_DL = 2'h0,
    FMT_UL_RSA = 2'h1,
    FMT_PIC_MAI = 2'h2,
    FMT_GENERIC = 2'h3
  } aldc_ifmt_e;

  typedef struct packed {
    logic [5:0] adr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } aldc_bus_s;

  typedef struct packed {
    logic [3:0] valid;
    logic [3:0][2:0] link;
  } aldc_dest_s;

  typedef struct packed {
    logic [3:0] dest;
    logic [1:0] agg_mode;
    logic agg_err_en;
    logic hdr_sel;
    logic [1:0] cin_fmt;
    logic [1:0] cout_fmt;
    logic dec_en;
    logic dec_burst8;
    logic [1:0] cpri_fmt;
    logic cap_en;
    logic [2:0] ram_ofs;
  } aldc_link_s;

endpackage : aldc_pkg

// file: tb/aldc_config_asserts.sv
`timescale 1ns/1ps
module aldc_config_chk (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [5:0] adr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic [5:0] enc_req_i,
  input wire aldc_pkg::aldc_dest_s decomb0_dest_o,
  input wire aldc_pkg::aldc_link_s [5:0] link_cfg_o,
  input wire logic [5:0] agg_to_mac_en_o,
  input wire logic [5:0] agg_use_comb_o,
  input wire logic [5:0] agg_use_enc_o,
  input wire logic [5:0] agg_honour_enc_o
);
  // ------------------------------------------------------------
  // per-link fields and the destination-entry valid decode gathered into vectors
  // ------------------------------------------------------------
  logic [5:0] hi, lo, b8, of0, en;
  logic [3:0] dv;
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      hi[i] = link_cfg_o[i].agg_mode[1];
      lo[i] = link_cfg_o[i].agg_mode[0];
      b8[i] = link_cfg_o[i].dec_burst8;
      of0[i] = link_cfg_o[i].ram_ofs[0];
      en[i] = link_cfg_o[i].dec_en;
    end
    for (int k = 0; k < 4; k++) dv[k] = decomb0_dest_o.link[k] < 3'h6;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  sequence s_link_wr;
    wr_i && adr_i == 6'h01;
  endsequence
  a_rd_idle: assert property (!rd_i |=> rdata_o == 32'h0)
    else $error("read data outside read slot");
  a_unmapped_zero: assert property (rd_i && adr_i == 6'h3F |=> rdata_o == 32'h0)
    else $error("unmapped read not zero");
  a_mac_enable: assert property (agg_to_mac_en_o == (hi | lo))
    else $error("mac enable wrong");
  a_pass_comb: assert property (agg_use_comb_o == lo)
    else $error("combiner pass wrong");
  a_insert_enc: assert property (agg_use_enc_o == hi)
    else $error("encoder insert wrong");
  a_honour_enc: assert property (agg_honour_enc_o == (hi & enc_req_i))
    else $error("encoder signalling wrong");
  // live mode may only change through zero, so a nonzero mode never steps to another
  a_mode_hold: assert property ((($past({hi, lo}) ^ {hi, lo})
    & {2{$past(hi | lo) & (hi | lo)}}) == 12'h0) else $error("live mode changed while on");
  a_burst_lsb: assert property ((b8 & of0) == 6'h0)
    else $error("offset lsb kept under burst of eight");
  a_dest_empty: assert property (decomb0_dest_o.valid == dv)
    else $error("destination empty decode wrong");
  a_link_wr: assert property (s_link_wr |=> en == $past(wdata_i[5:0]))
    else $error("link enable not updated");
endmodule : aldc_config_chk

bind aldc_config aldc_config_chk i_chk (.clk_i, .nrst_i, .adr_i, .wdata_i, .wr_i, .rd_i,
  .rdata_o, .enc_req_i, .decomb0_dest_o, .link_cfg_o, .agg_to_mac_en_o, .agg_use_comb_o,
  .agg_use_enc_o, .agg_honour_enc_o);

// file: tb/aldc_config_tb.sv
`timescale 1ns/1ps
module aldc_config_tb;
  localparam logic [13:0] MODES = 14'h3224;
  localparam logic [13:0] LIVES = 14'h3214;
  logic clk_i, nrst_i, wr_i, rd_i;
  logic [5:0] adr_i, enc_req_i, hdr_mismatch_i, obsai_mode_i, a;
  logic [31:0] wdata_i, rdata_o, got, v;
  logic [31:0] shadow [64];
  logic [12:0] msg_adr_i;
  aldc_pkg::aldc_dest_s decomb0_dest_o;
  aldc_pkg::aldc_link_s [5:0] link_cfg_o;
  logic [5:0] agg_to_mac_en_o, agg_use_comb_o, agg_use_enc_o, agg_honour_enc_o, agg_pick_enc_o;
  logic [9:0] lut_index_o, exp_idx;
  int bad_count, comparisons;
  aldc_config i_dut (.clk_i, .nrst_i, .adr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .msg_adr_i,
    .enc_req_i, .hdr_mismatch_i, .obsai_mode_i, .decomb0_dest_o, .link_cfg_o, .agg_to_mac_en_o,
    .agg_use_comb_o, .agg_use_enc_o, .agg_honour_enc_o, .agg_pick_enc_o, .lut_index_o);
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  task automatic end_of_test;
    if (bad_count == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // reserved bits between the per-link groups must read back as zero
  function automatic logic [31:0] mask_of(input logic [5:0] ad);
    if (ad == 6'h00) return 32'h0000_7777;
    if (ad == 6'h01) return 32'h0FFF_3F3F;
    if (ad == 6'h02) return 32'h3F03_FFFF;
    if (ad == 6'h03) return 32'h000F_FFFF;
    if (ad inside {[6'h08:6'h0D]}) return 32'h0000_000F;
    if (ad inside {[6'h10:6'h15], [6'h18:6'h1D]}) return 32'h0000_0003;
    return 32'h0;
  endfunction : mask_of
  // per-link hit mask over the four destination entries; empty codes never hit
  function automatic logic [3:0] hit_of(input logic [31:0] t, input int l);
    logic [3:0] h;
    for (int k = 0; k < 4; k++) h[k] = (t[4 * k +: 3] == l[2:0]) && (l < 6);
    return h;
  endfunction : hit_of
  task automatic wr(input logic [5:0] ad, input logic [31:0] d);
    adr_i <= ad;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    shadow[ad] = d & mask_of(ad);
  endtask : wr
  task automatic rd(input logic [5:0] ad);
    adr_i <= ad;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(negedge clk_i);
    got = rdata_o;
    @(posedge clk_i);
  endtask : rd
  task automatic chk_out;
    for (int i = 0; i < 6; i++) begin
      chk("cin_fmt", shadow[6'h10 + i][1:0], link_cfg_o[i].cin_fmt);
      chk("cout_fmt", shadow[6'h18 + i][1:0], link_cfg_o[i].cout_fmt);
      chk("hdr_sel", shadow[6'h08 + i][3], link_cfg_o[i].hdr_sel);
      chk("err_en", shadow[6'h08 + i][2], link_cfg_o[i].agg_err_en);
      chk("dest_hit", hit_of(shadow[0], i), link_cfg_o[i].dest);
      chk("dec_en", shadow[1][i], link_cfg_o[i].dec_en);
      chk("burst8", shadow[1][8 + i], link_cfg_o[i].dec_burst8);
      chk("cpri_fmt", shadow[1][16 + 2 * i +: 2], link_cfg_o[i].cpri_fmt);
      chk("cap_en", shadow[2][24 + i], link_cfg_o[i].cap_en);
      chk("ram_ofs", shadow[2][3 * i +: 3] & {2'h3, ~shadow[1][8 + i]}, link_cfg_o[i].ram_ofs);
    end
    for (int k = 0; k < 4; k++) begin
      chk("dest", shadow[0][4 * k +: 3], decomb0_dest_o.link[k]);
      chk("dest_valid", shadow[0][4 * k +: 3] < 3'h6, decomb0_dest_o.valid[k]);
    end
  endtask : chk_out
  initial begin
    #100000;
    bad_count++;
    end_of_test();
  end
  initial begin
    {nrst_i, wr_i, rd_i, adr_i, wdata_i, msg_adr_i} = '0;
    {enc_req_i, hdr_mismatch_i, obsai_mode_i} = '0;
    foreach (shadow[i]) shadow[i] = 32'h0;
    void'($urandom(94485));
    repeat (4) @(posedge clk_i);
    nrst_i <= 1'b1;
    for (int i = 0; i < 64; i++) if (i != 32) begin
      rd(6'(i));
      chk("reset", 32'h0, got);
    end
    repeat (300) begin
      do a = 6'($urandom_range(63)); while (a == 6'h20);
      wr(a, $urandom());
      rd(a);
      chk("readback", shadow[a], got);
      chk_out();
    end
    for (int j = 0; j < 7; j++) begin
      enc_req_i <= 6'($urandom());
      wr(6'h08, {30'h0, MODES[2 * j +: 2]});
      @(negedge clk_i);
      chk("live_mode", LIVES[2 * j +: 2], link_cfg_o[0].agg_mode);
      chk("to_mac", |LIVES[2 * j +: 2], agg_to_mac_en_o[0]);
      chk("use_comb", LIVES[2 * j], agg_use_comb_o[0]);
      chk("use_enc", LIVES[2 * j + 1], agg_use_enc_o[0]);
      chk("honour", LIVES[2 * j + 1] & enc_req_i[0], agg_honour_enc_o[0]);
      @(posedge clk_i);
    end
    hdr_mismatch_i <= 6'h3F;
    enc_req_i <= 6'h3F;
    for (int h = 0; h < 3; h++) begin
      obsai_mode_i <= (h < 2) ? 6'h3F : 6'h00;
      wr(6'h08, (h == 1) ? 32'hB : 32'h3);
      @(negedge clk_i);
      chk("pick_enc", (h != 0), agg_pick_enc_o[0]);
      @(posedge clk_i);
    end
    repeat (40) begin
      v = $urandom();
      wr(6'h03, v);
      msg_adr_i <= 13'($urandom());
      @(posedge clk_i);
      @(negedge clk_i);
      for (int n = 0; n < 10; n++) exp_idx[n] = msg_adr_i[n + v[2 * n +: 2]];
      chk("lut_index", exp_idx, lut_index_o);
      @(posedge clk_i);
    end
    end_of_test();
  end
endmodule : aldc_config_tb
